// [bench/dso_assertions.sv]
// port-level checker for the drive status output block.
// assumes the bind below, one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dso_assertions (
	input wire        clk_in,
	input wire        rst_in,
	input wire [7:0]  reg_addr_in,
	input wire        reg_rd_in,
	input wire [31:0] reg_rdata_out,
	input wire        rx_frame_in,
	input wire        rx_ascii_in,
	input wire        forward_run_in,
	input wire        reverse_run_in,
	input wire [4:0]  terminal_out,
	input wire        alarm_relay_out,
	input wire        motor_stop_out,
	input wire [2:0]  comm_error_action_out,
	input wire        irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ascii frames never restart the silence count
	wire rtu_w = rx_frame_in & ~rx_ascii_in;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_rst_quiet;
		$fell(rst_in) |-> ({terminal_out, alarm_relay_out, motor_stop_out,
			comm_error_action_out, irq_out, reg_rdata_out} == '0);
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs busy after reset");
	property p_rd_idle;
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without a read");
	property p_rd_unmapped;
		reg_rd_in && reg_addr_in > 8'h54 |=> reg_rdata_out == 32'h0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read not zero");
	property p_rd_upper;
		reg_rd_in |=> reg_rdata_out[31:18] == 14'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read bits not zero");
	property p_stop_on;
		(forward_run_in && reverse_run_in) [*8] |-> motor_stop_out;
	endproperty
	a_stop_on: assert property (p_stop_on)
		else $error("both run inputs but motor not stopped");
	property p_stop_off;
		(!forward_run_in || !reverse_run_in) [*8] |-> !motor_stop_out;
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("motor stop without both run inputs");
	property p_rtu_clear;
		rtu_w |-> ##2 comm_error_action_out == 3'h0;
	endproperty
	a_rtu_clear: assert property (p_rtu_clear)
		else $error("timeout action stays after frame");
	property p_no_early;
		$rose(comm_error_action_out != 3'h0) |-> !$past(rtu_w, 2)
			&& !$past(rtu_w, 3);
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("timeout raised right after frame");
endmodule // dso_assertions

bind dso_top dso_assertions u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .rx_frame_in(rx_frame_in),
	.rx_ascii_in(rx_ascii_in), .forward_run_in(forward_run_in),
	.reverse_run_in(reverse_run_in), .terminal_out(terminal_out),
	.alarm_relay_out(alarm_relay_out), .motor_stop_out(motor_stop_out),
	.comm_error_action_out(comm_error_action_out), .irq_out(irq_out));

// [bench/dso_machinery.sv]
// model of the machinery that reads the output terminals.
// assumes it shares clk_in with the drive.
`timescale 1ns/1ps
module dso_machinery (
	input  wire       clk_in,
	input  wire [4:0] terminal_in,
	input  wire       alarm_in,
	output reg  [5:0] seen_out
);
	// one input register, as a plc scan adds a cycle of lag
	always @(posedge clk_in) begin
		seen_out <= {alarm_in, terminal_in};
	end
endmodule // dso_machinery

// [bench/dso_top_tb_top.sv]
// self-checking bench for the drive status output block.
// assumes short ms ticks and a small life limit to keep the run brief.
`timescale 1ns/1ps
`include "dso_map.vh"
module dso_top_tb_top;
	logic        clk_in, rst_in, reg_wr_in, reg_rd_in, rd_d;
	logic [7:0]  reg_addr_in, fan_in, heat_in, itemp_in, cur_in;
	logic [31:0] reg_wdata_in;
	logic        rx_frame_in, rx_ascii_in, fw_in, rv_in;
	logic        accel_in, decel_in, const_in;
	logic [63:0] ext_in, note;
	logic [63:0] notes[$];
	wire  [31:0] reg_rdata_out;
	wire  [4:0]  terminal_out;
	wire  [2:0]  act_out;
	wire  [5:0]  seen;
	wire         alarm_out, stop_out, irq_out;
	int          err_total, checks_done, i, k, e;
	logic [7:0]  ra[7] = '{8'h08, 8'h10, 8'h30, 8'h44, 8'h00, 8'h54, 8'h60};
	logic [7:0]  rv[7] = '{8'h5A, 8'h64, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

	dso_top #(.MS_CYCLES(10), .LIFE_LIMIT(32'h4)) uut (.clk_in(clk_in),
		.rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.rx_frame_in(rx_frame_in), .rx_ascii_in(rx_ascii_in),
		.forward_run_in(fw_in), .reverse_run_in(rv_in),
		.fan_speed_pct_in(fan_in), .heatsink_temp_in(heat_in),
		.internal_temp_in(itemp_in), .out_current_pct_in(cur_in),
		.accel_in(accel_in), .decel_in(decel_in), .const_speed_in(const_in),
		.ext_flags_in(ext_in), .terminal_out(terminal_out),
		.alarm_relay_out(alarm_out), .motor_stop_out(stop_out),
		.comm_error_action_out(act_out), .irq_out(irq_out));
	dso_machinery u_mach (.clk_in(clk_in), .terminal_in(terminal_out),
		.alarm_in(alarm_out), .seen_out(seen));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input [31:0] s, input [31:0] x);
		checks_done++;
		if (s !== x) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a used-up wait ends the run at once
	task automatic lim(input int n, input int m);
		if (n >= m) begin
			chk("wait bound", 32'h0, 32'h1);
			stop_test();
		end
	endtask
	// wait whole cycles, then look at settled outputs
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in    <= 1'b0;
	endtask
	// note the expectation first, the monitor checks it next cycle
	task automatic rd(input [7:0] a, input [31:0] m, input [31:0] x);
		notes.push_back({m, x});
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in   <= 1'b0;
	endtask
	task automatic rtu(input logic asc);
		@(posedge clk_in);
		rx_frame_in <= 1'b1;
		rx_ascii_in <= asc;
		@(posedge clk_in);
		rx_frame_in <= 1'b0;
		rx_ascii_in <= 1'b0;
	endtask
	function automatic logic opf(int o, logic a, logic b);
		return o == 0 ? a & b : o == 1 ? a | b : o == 2 ? a ^ b : 1'b0;
	endfunction

	// read monitor: data stand one cycle after the strobe
	always @(posedge clk_in) begin
		rd_d <= reg_rd_in;
		if (rd_d && notes.size() > 0) begin
			note = notes.pop_front();
			chk("read data", reg_rdata_out & note[63:32], note[31:0]);
		end
	end
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_in, rd_d, reg_wr_in, reg_rd_in} = 4'h8;
		{reg_addr_in, reg_wdata_in, ext_in} = '0;
		{rx_frame_in, rx_ascii_in, fw_in, rv_in} = 4'h0;
		{accel_in, decel_in, const_in} = 3'h4;
		{fan_in, heat_in, itemp_in, cur_in} = 32'h6419_2896;
		err_total = 0;
		checks_done = 0;
		void'($urandom(78));
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		ext_in <= {$urandom, $urandom};
		for (k = 0; k < 7; k++) rd(ra[k], 32'hFFFFFFFF, rv[k]);
		// overheat on terminal 1, boundary then random levels
		wr(`DSO_REG_TERM_BASE, 32'h2A);
		for (k = 0; k < 8; k++) begin
			e = k < 2 ? 8'h5A + k : $urandom % 256;
			@(posedge clk_in);
			heat_in <= e[7:0];
			settle(4);
			chk("overheat", terminal_out[0], e > 8'h5A);
		end
		// six combos over overheat and low current, on all outputs
		for (k = 0; k < 6; k++) begin
			wr(`DSO_REG_COMBO_BASE + 4 * k, 32'h2B2A | ((k % 4) << 16));
			wr(`DSO_REG_TERM_BASE + 4 * k, 32'h21 + k);
		end
		for (i = 0; i < 4; i++) begin
			@(posedge clk_in);
			heat_in <= i[1] ? 8'hC8 : 8'h00;
			cur_in  <= i[0] ? 8'h00 : 8'h96;
			settle(8);
			for (k = 0; k < 6; k++)
				chk("combo", seen[k], opf(k % 4, i[1], i[0]));
		end
		// low current against mode and motion state, then boundary
		for (i = 0; i < 6; i++) begin
			wr(`DSO_REG_LOWCUR_MODE, i / 3);
			{accel_in, decel_in, const_in} <= 3'h4 >> (i % 3);
			settle(3);
			e = (i < 3 || i == 5) ? 32'h200 : 0;
			rd(`DSO_REG_FLAGS, 32'h200, e);
		end
		cur_in <= 8'h64;
		settle(3);
		rd(`DSO_REG_FLAGS, 32'h200, 32'h0);
		// fan: 75 and 76 percent, then fan stopped on purpose or not
		for (i = 0; i < 4; i++) begin
			wr(`DSO_REG_FAN_CTRL, i / 2);
			fan_in <= i == 0 ? 8'd75 : i == 1 ? 8'd76 : 8'd0;
			const_in <= i == 3;
			settle(3);
			e = (i == 0 || i == 3) ? 32'h40 : 0;
			rd(`DSO_REG_FLAGS, 32'h40, e);
		end
		// run contact and stop on both run inputs
		wr(`DSO_REG_TERM_BASE, 32'h29);
		for (i = 1; i < 5; i++) begin
			@(posedge clk_in);
			{fw_in, rv_in} <= i[1:0];
			settle(10);
			chk("run contact", seen[0], i == 1 || i == 2);
			chk("motor stop", stop_out, i == 3);
		end
		// link timeout with interrupt, ascii traffic and masking
		wr(`DSO_REG_IRQ_MASK, 32'h1);
		wr(`DSO_REG_TIMEOUT_ACT, 32'h5);
		rtu(1'b0);
		wr(`DSO_REG_COMM_TIMEOUT, 32'h2);
		settle(15);
		chk("early timeout", act_out, 3'h0);
		for (i = 0; i < 40 && act_out === 3'h0; i++) settle(1);
		lim(i, 40);
		chk("timeout action", act_out, 3'h5);
		settle(2);
		chk("irq set", irq_out, 1'b1);
		rtu(1'b1);
		settle(3);
		chk("ascii ignored", act_out, 3'h5);
		rd(`DSO_REG_IRQ_STATUS, 32'h1, 32'h1);
		settle(3);
		chk("irq cleared", irq_out, 1'b0);
		rtu(1'b0);
		settle(2);
		chk("timeout left", act_out, 3'h0);
		wr(`DSO_REG_IRQ_MASK, 32'h0);
		for (i = 0; i < 40 && act_out === 3'h0; i++) settle(1);
		lim(i, 40);
		settle(2);
		chk("irq masked", irq_out, 1'b0);
		wr(`DSO_REG_IRQ_MASK, 32'h1);
		settle(2);
		chk("irq unmasked", irq_out, 1'b1);
		rd(`DSO_REG_IRQ_STATUS, 32'h1, 32'h1);
		// capacitor life on the alarm relay, hot to age quickly
		wr(`DSO_REG_TERM_BASE + 8'h14, 32'h27);
		itemp_in <= 8'd110;
		settle(3);
		chk("life early", alarm_out, 1'b0);
		for (i = 0; i < 11000 && alarm_out !== 1'b1; i++) settle(1);
		lim(i, 11000);
		rd(`DSO_REG_LIFE_MON, 32'h1, 32'h1);
		settle(3);
		stop_test();
	end
endmodule // dso_top_tb_top

// [hw/dso_map.vh]
// constants for the drive status output block: register offsets,
// field positions, reset values, option codes and timing figures.
// assumes a 50 MHz clock and a byte-addressed plain register port.
`ifndef DSO_MAP_VH
`define DSO_MAP_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DSO_CLK_PERIOD_NS 20
`define DSO_MS_NS         1000000
`define DSO_MS_PER_S      10'd1000

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DSO_REG_COMM_TIMEOUT  8'h00
`define DSO_REG_TIMEOUT_ACT   8'h04
`define DSO_REG_OVERHEAT_LVL  8'h08
`define DSO_REG_LOWCUR_MODE   8'h0C
`define DSO_REG_LOWCUR_LVL    8'h10
`define DSO_REG_FAN_CTRL      8'h14
`define DSO_REG_COMBO_BASE    8'h18
`define DSO_REG_TERM_BASE     8'h30
`define DSO_REG_FLAGS         8'h48
`define DSO_REG_LIFE_MON      8'h4C
`define DSO_REG_IRQ_STATUS    8'h50
`define DSO_REG_IRQ_MASK      8'h54

// ---------------------------------------------------------------
// combo register fields
// ---------------------------------------------------------------
`define DSO_COMBO_A_LSB  0
`define DSO_COMBO_B_LSB  8
`define DSO_COMBO_OP_LSB 16
`define DSO_OP_AND       2'h0
`define DSO_OP_OR        2'h1
`define DSO_OP_XOR       2'h2

// ---------------------------------------------------------------
// option codes of the flags made here
// ---------------------------------------------------------------
`define DSO_OPT_LINK_TIMEOUT 6'h20
`define DSO_OPT_COMBO_FIRST  6'h21
`define DSO_OPT_CAP_LIFE     6'h27
`define DSO_OPT_LOW_FAN      6'h28
`define DSO_OPT_RUN_CONTACT  6'h29
`define DSO_OPT_OVERHEAT     6'h2A
`define DSO_OPT_LOW_CURRENT  6'h2B

// ---------------------------------------------------------------
// reset values and fixed figures
// ---------------------------------------------------------------
`define DSO_RST_COMM_TIMEOUT 16'h0000
`define DSO_RST_TERM_SEL     8'hFF
`define DSO_RST_OVERHEAT_LVL 8'h5A
`define DSO_RST_LOWCUR_LVL   8'h64
`define DSO_FAN_LOW_PCT      8'h4B
`define DSO_FAN_ONLY_RUN     1'h1
`define DSO_LOWCUR_CONST     1'h1
`define DSO_LIFE_BASE_C      8'h28
`define DSO_LIFE_STEP_C      8'h0A

`endif

// [hw/dso_top.v]
// drive status output logic: status flags, combo outputs, terminal
// selection, interrupt and register port, all in one module.
// assumes measurement values come from logic on clk_in; the run
// terminals come straight from pins and are synchronised here.
`timescale 1ns/1ps
`include "dso_map.vh"

// Summary of operation
// RULE1 - flag link timeout after configured silence exceeded
// RULE2 - timeout flag holds until RTU traffic resumes
// RULE3 - only RTU framed traffic affects timeout flag
// RULE4 - timeout reaction comes from action select setting
// RULE5 - six combo outputs, codes 33 to 38
// RULE6 - operator codes: 00 AND, 01 OR, 02 XOR
// RULE7 - each combo: A select, B select, operator
// RULE8 - capacitor life from temperature and power-on time
// RULE9 - low fan flag at 75 percent or less
// RULE10 - no fan flag while fan deliberately stopped
// RULE11 - run contact follows forward/reverse run inputs
// RULE12 - both run inputs: stop motor, contact off
// RULE13 - overheat flag when heatsink above level
// RULE14 - low current mode selects allowed motion states
// RULE15 - low current flag below level in mode
// RULE16 - terminal speed source: prefer mode 00 or filter; no speed source select here, const_speed_in is taken as given
// RULE17 - terminals show only their selected flag
module dso_top #(
	parameter MS_CYCLES = `DSO_MS_NS / `DSO_CLK_PERIOD_NS,
	parameter [31:0] LIFE_LIMIT = 32'h12CC_0300
) (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire [7:0]  reg_addr_in,
	input  wire [31:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output wire [31:0] reg_rdata_out,
	input  wire        rx_frame_in,
	input  wire        rx_ascii_in,
	input  wire        forward_run_in,
	input  wire        reverse_run_in,
	input  wire [7:0]  fan_speed_pct_in,
	input  wire [7:0]  heatsink_temp_in,
	input  wire [7:0]  internal_temp_in,
	input  wire [7:0]  out_current_pct_in,
	input  wire        accel_in,
	input  wire        decel_in,
	input  wire        const_speed_in,
	input  wire [63:0] ext_flags_in,
	output wire [4:0]  terminal_out,
	output wire        alarm_relay_out,
	output wire        motor_stop_out,
	output wire [2:0]  comm_error_action_out,
	output wire        irq_out
);

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------

	// pick one flag by option code; codes past 63 pick nothing
	function pick_flag;
		input [63:0] vec;
		input [7:0]  code;
		begin
			pick_flag = (code[7:6] == 2'h0) ? vec[code[5:0]] : 1'b0;
		end
	endfunction

	// two-input operator; unknown code gives low
	function combo_op;
		input       a;
		input       b;
		input [1:0] op;
		begin
			case (op)
			`DSO_OP_AND: combo_op = a & b;
			`DSO_OP_OR:  combo_op = a | b;
			`DSO_OP_XOR: combo_op = a ^ b;
			default:     combo_op = 1'b0;
			endcase
		end
	endfunction

	// hit on word k of a run of registers starting at base
	function slot_hit;
		input [7:0] addr, base;
		input [2:0] idx;
		slot_hit = (addr == base + {3'h0, idx, 2'h0});
	endfunction

	// ---------------------------------------------------------------
	// registers and state
	// ---------------------------------------------------------------
	reg  [15:0] comm_timeout_setting_r;
	reg  [2:0]  timeout_action_select_r;
	reg  [7:0]  overheat_warn_level_r;
	reg         low_current_mode_select_r;
	reg  [7:0]  low_current_detect_level_r;
	reg         cooling_fan_control_r;
	reg  [17:0] combo_cfg_r [0:5];
	reg  [7:0]  term_sel_r  [0:5];
	reg  [4:0]  irq_status_r;
	reg  [4:0]  irq_mask_r;
	reg  [31:0] rdata_r;
	reg  [31:0] rdata_nxt;

	reg  [2:0]  fw_sync_r;
	reg  [2:0]  rv_sync_r;
	reg         fw_r;
	reg         rv_r;

	reg  [31:0] ms_div_r;
	reg         ms_tick_r;
	reg  [15:0] silent_ms_r;
	reg         link_timeout_r;
	reg  [9:0]  sec_div_r;
	reg  [31:0] life_used_r;

	reg         capacitor_life_warn_r;
	reg         low_fan_speed_warn_r;
	reg         run_contact_out_r;
	reg         heatsink_overheat_warn_r;
	reg         low_current_flag_r;
	reg  [5:0]  combo_r;
	reg  [4:0]  flag_prev_r;

	reg  [4:0]  terminal_r;
	reg         alarm_relay_r;
	reg         motor_stop_r;
	reg  [2:0]  comm_action_r;
	reg         irq_r;

	wire [63:0] flag_vec;
	wire [4:0]  event_flags;
	wire [4:0]  event_rise;
	wire        rtu_frame;
	wire        motion;
	wire [7:0]  temp_excess;
	wire [2:0]  life_shift;
	integer     i_wr, i_rd, i_cb, i_tm;

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			comm_timeout_setting_r     <= `DSO_RST_COMM_TIMEOUT;
			timeout_action_select_r    <= 3'h0;
			overheat_warn_level_r      <= `DSO_RST_OVERHEAT_LVL;
			low_current_mode_select_r  <= 1'b0;
			low_current_detect_level_r <= `DSO_RST_LOWCUR_LVL;
			cooling_fan_control_r      <= 1'b0;
			irq_mask_r                 <= 5'h00;
			for (i_wr = 0; i_wr < 6; i_wr = i_wr + 1) begin
				combo_cfg_r[i_wr] <= 18'h00000;
				term_sel_r[i_wr]  <= `DSO_RST_TERM_SEL;
			end
		end else if (reg_wr_in) begin
			case (reg_addr_in)
			`DSO_REG_COMM_TIMEOUT:
				comm_timeout_setting_r <= reg_wdata_in[15:0];
			`DSO_REG_TIMEOUT_ACT:
				timeout_action_select_r <= reg_wdata_in[2:0];
			`DSO_REG_OVERHEAT_LVL:
				overheat_warn_level_r <= reg_wdata_in[7:0];
			`DSO_REG_LOWCUR_MODE:
				low_current_mode_select_r <= reg_wdata_in[0];
			`DSO_REG_LOWCUR_LVL:
				low_current_detect_level_r <= reg_wdata_in[7:0];
			`DSO_REG_FAN_CTRL:
				cooling_fan_control_r <= reg_wdata_in[0];
			`DSO_REG_IRQ_MASK:
				irq_mask_r <= reg_wdata_in[4:0];
			default: begin
				// combo and terminal selects sit in two runs of words
				for (i_wr = 0; i_wr < 6; i_wr = i_wr + 1) begin
					if (slot_hit(reg_addr_in, `DSO_REG_COMBO_BASE, i_wr[2:0]))
						combo_cfg_r[i_wr] <= reg_wdata_in[17:0]; // see RULE7
					if (slot_hit(reg_addr_in, `DSO_REG_TERM_BASE, i_wr[2:0]))
						term_sel_r[i_wr] <= reg_wdata_in[7:0];
				end
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// register reads, data one cycle after the strobe
	// ---------------------------------------------------------------
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (reg_addr_in)
		`DSO_REG_COMM_TIMEOUT: rdata_nxt[15:0] = comm_timeout_setting_r;
		`DSO_REG_TIMEOUT_ACT:  rdata_nxt[2:0]  = timeout_action_select_r;
		`DSO_REG_OVERHEAT_LVL: rdata_nxt[7:0]  = overheat_warn_level_r;
		`DSO_REG_LOWCUR_MODE:  rdata_nxt[0]    = low_current_mode_select_r;
		`DSO_REG_LOWCUR_LVL:   rdata_nxt[7:0]  = low_current_detect_level_r;
		`DSO_REG_FAN_CTRL:     rdata_nxt[0]    = cooling_fan_control_r;
		`DSO_REG_FLAGS:        rdata_nxt[15:0] = {flag_vec[38:33],
			flag_vec[43:39], 4'h0, link_timeout_r};
		`DSO_REG_LIFE_MON:     rdata_nxt[1:0]  = {low_fan_speed_warn_r,
			capacitor_life_warn_r};
		`DSO_REG_IRQ_STATUS:   rdata_nxt[4:0]  = irq_status_r;
		`DSO_REG_IRQ_MASK:     rdata_nxt[4:0]  = irq_mask_r;
		default: begin
			for (i_rd = 0; i_rd < 6; i_rd = i_rd + 1) begin
				if (slot_hit(reg_addr_in, `DSO_REG_COMBO_BASE, i_rd[2:0]))
					rdata_nxt[17:0] = combo_cfg_r[i_rd];
				if (slot_hit(reg_addr_in, `DSO_REG_TERM_BASE, i_rd[2:0]))
					rdata_nxt[7:0] = term_sel_r[i_rd];
			end
		end
		endcase
	end

	// read data stand only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (rst_in)
			rdata_r <= 32'h0000_0000;
		else if (reg_rd_in)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= 32'h0000_0000;
	end

	// ---------------------------------------------------------------
	// run terminal synchronisers
	// ---------------------------------------------------------------
	// stage one feeds only stage two; a change counts once 2 and 3 agree
	always @(posedge clk_in) begin
		if (rst_in) begin
			fw_sync_r <= 3'h0;
			rv_sync_r <= 3'h0;
			fw_r      <= 1'b0;
			rv_r      <= 1'b0;
		end else begin
			fw_sync_r <= {fw_sync_r[1:0], forward_run_in};
			rv_sync_r <= {rv_sync_r[1:0], reverse_run_in};
			if (fw_sync_r[1] == fw_sync_r[2])
				fw_r <= fw_sync_r[2];
			if (rv_sync_r[1] == rv_sync_r[2])
				rv_r <= rv_sync_r[2];
		end
	end

	// ---------------------------------------------------------------
	// millisecond and second ticks
	// ---------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			ms_div_r  <= 32'h0000_0000;
			ms_tick_r <= 1'b0;
			sec_div_r <= 10'h000;
		end else begin
			ms_tick_r <= (ms_div_r == MS_CYCLES - 1);
			if (ms_div_r == MS_CYCLES - 1)
				ms_div_r <= 32'h0000_0000;
			else
				ms_div_r <= ms_div_r + 32'h0000_0001;
			if (ms_tick_r)
				sec_div_r <= (sec_div_r == `DSO_MS_PER_S - 10'h001) ?
					10'h000 : sec_div_r + 10'h001;
		end
	end

	// ---------------------------------------------------------------
	// link timeout
	// ---------------------------------------------------------------
	// ascii frames are dropped here so they never refresh the timer
	assign rtu_frame = rx_frame_in & ~rx_ascii_in; // see RULE3

	// a zero setting disables detection altogether
	always @(posedge clk_in) begin
		if (rst_in) begin
			silent_ms_r    <= 16'h0000;
			link_timeout_r <= 1'b0;
		end else if (rtu_frame) begin
			silent_ms_r    <= 16'h0000;
			link_timeout_r <= 1'b0; // see RULE2
		end else begin
			if (ms_tick_r && silent_ms_r != 16'hFFFF)
				silent_ms_r <= silent_ms_r + 16'h0001;
			if (comm_timeout_setting_r != 16'h0000 &&
				silent_ms_r > comm_timeout_setting_r)
				link_timeout_r <= 1'b1; // see RULE1
		end
	end

	// ---------------------------------------------------------------
	// capacitor life estimate
	// ---------------------------------------------------------------
	// wear doubles per step above the base temperature, capped at 128x
	assign temp_excess = (internal_temp_in > `DSO_LIFE_BASE_C) ?
		(internal_temp_in - `DSO_LIFE_BASE_C) / `DSO_LIFE_STEP_C : 8'h00;
	assign life_shift = (temp_excess > 8'h07) ? 3'h7 : temp_excess[2:0];

	always @(posedge clk_in) begin
		if (rst_in) begin
			life_used_r           <= 32'h0000_0000;
			capacitor_life_warn_r <= 1'b0;
		end else begin
			if (ms_tick_r && sec_div_r == `DSO_MS_PER_S - 10'h001 &&
				life_used_r < LIFE_LIMIT)
				life_used_r <= life_used_r + (32'h1 << life_shift);
			capacitor_life_warn_r <= (life_used_r >= LIFE_LIMIT); // see RULE8
		end
	end

	// ---------------------------------------------------------------
	// simple status flags
	// ---------------------------------------------------------------
	assign motion = accel_in | decel_in | const_speed_in;

	always @(posedge clk_in) begin
		if (rst_in) begin
			low_fan_speed_warn_r     <= 1'b0;
			run_contact_out_r        <= 1'b0;
			motor_stop_r             <= 1'b0;
			heatsink_overheat_warn_r <= 1'b0;
			low_current_flag_r       <= 1'b0;
		end else begin
			// a parked fan in run-only mode is not a slow fan
			low_fan_speed_warn_r <= (fan_speed_pct_in <= `DSO_FAN_LOW_PCT) &&
				!(cooling_fan_control_r == `DSO_FAN_ONLY_RUN && !motion); // see RULE9 see RULE10
			// run contact ignores the command source on purpose
			run_contact_out_r <= (fw_r | rv_r) & ~(fw_r & rv_r); // see RULE11 see RULE12
			motor_stop_r      <= fw_r & rv_r; // see RULE12
			heatsink_overheat_warn_r <=
				(heatsink_temp_in > overheat_warn_level_r); // see RULE13
			// with terminal speed input, constant speed may be missed
			low_current_flag_r <=
				(out_current_pct_in < low_current_detect_level_r) &&
				((low_current_mode_select_r == `DSO_LOWCUR_CONST) ?
				const_speed_in : motion); // see RULE14 see RULE15
		end
	end

	// ---------------------------------------------------------------
	// combo outputs
	// ---------------------------------------------------------------
	// combos read the vector holding their own last value, a one-cycle
	// lag that avoids a loop when one combo feeds another
	assign flag_vec = {ext_flags_in[63:44], low_current_flag_r,
		heatsink_overheat_warn_r, run_contact_out_r, low_fan_speed_warn_r,
		capacitor_life_warn_r, combo_r, link_timeout_r,
		ext_flags_in[31:0]};

	always @(posedge clk_in) begin
		if (rst_in)
			combo_r <= 6'h00;
		else
			for (i_cb = 0; i_cb < 6; i_cb = i_cb + 1)
				combo_r[i_cb] <= combo_op(
					pick_flag(flag_vec, {2'h0,
						combo_cfg_r[i_cb][`DSO_COMBO_A_LSB +: 6]}),
					pick_flag(flag_vec, {2'h0,
						combo_cfg_r[i_cb][`DSO_COMBO_B_LSB +: 6]}),
					combo_cfg_r[i_cb][`DSO_COMBO_OP_LSB +: 2]); // see RULE5 see RULE6
	end

	// ---------------------------------------------------------------
	// terminals, timeout reaction, interrupt
	// ---------------------------------------------------------------
	assign event_flags = {low_current_flag_r, heatsink_overheat_warn_r,
		low_fan_speed_warn_r, capacitor_life_warn_r, link_timeout_r};
	assign event_rise  = event_flags & ~flag_prev_r;

	always @(posedge clk_in) begin
		if (rst_in) begin
			terminal_r    <= 5'h00;
			alarm_relay_r <= 1'b0;
			comm_action_r <= 3'h0;
			flag_prev_r   <= 5'h00;
			irq_status_r  <= 5'h00;
			irq_r         <= 1'b0;
		end else begin
			for (i_tm = 0; i_tm < 5; i_tm = i_tm + 1)
				terminal_r[i_tm] <= pick_flag(flag_vec, term_sel_r[i_tm]); // see RULE17
			alarm_relay_r <= pick_flag(flag_vec, term_sel_r[5]); // see RULE17
			// zero means no reaction while no timeout stands
			comm_action_r <= link_timeout_r ? timeout_action_select_r :
				3'h0; // see RULE4
			flag_prev_r   <= event_flags;
			// a new event in the clearing read still lands
			irq_status_r  <= (irq_status_r &
				~((reg_rd_in && reg_addr_in == `DSO_REG_IRQ_STATUS) ?
				5'h1F : 5'h00)) | event_rise;
			irq_r         <= |(irq_status_r & irq_mask_r);
		end
	end

	assign reg_rdata_out         = rdata_r;
	assign terminal_out          = terminal_r;
	assign alarm_relay_out       = alarm_relay_r;
	assign motor_stop_out        = motor_stop_r;
	assign comm_error_action_out = comm_action_r;
	assign irq_out               = irq_r;

endmodule // dso_top
